// ### pkg/mic_pkg.sv
// Package for the mouse input conditioning block: timing figures and derived counts.
// Assumes a single 100 MHz reference clock drives every consumer of these constants.
package mic_pkg;

  localparam int unsigned MIC_CLK_HZ = 100_000_000;
  // Button debounce interval, in microseconds (15 ms).
  localparam int unsigned MIC_DEBOUNCE_US = 15_000;
  // Encoder sample interval, in microseconds.
  localparam int unsigned MIC_SAMPLE_US = 100;
  localparam int unsigned MIC_CYC_PER_US = MIC_CLK_HZ / 1_000_000;
  // Least time: microseconds times cycles per microsecond, the latter rounded down.
  localparam int unsigned MIC_DEBOUNCE_CYCLES = MIC_DEBOUNCE_US * MIC_CYC_PER_US;
  // Sampling period: rounded down, with no floor of one cycle.
  localparam int unsigned MIC_SAMPLE_CYCLES = MIC_SAMPLE_US * MIC_CYC_PER_US;
  localparam int unsigned MIC_BUTTONS = 3;
  localparam int unsigned MIC_SCROLL_WIDTH = 8;
  // Buttons are pulled up, so released reads high.
  localparam logic MIC_BUTTON_RESET = 1'b1;
  localparam logic [1:0] MIC_PHASE_RESET = 2'h0;

  typedef enum logic [1:0] {
    MIC_REST_LOW,
    MIC_REST_HIGH,
    MIC_MID_UP,
    MIC_MID_DOWN
  } mic_wheel_state_type;

endpackage : mic_pkg

// ### rtl/mic_debounce.sv
// One debounced button channel.
// Assumes its input is already synchronised to ref_clk_in.
`timescale 1ns/1ps
module mic_debounce
  import mic_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYCLES = MIC_DEBOUNCE_CYCLES
) (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic level_in,
  output logic stable_out
);

  logic stable_reg;
  logic stable_next;
  logic busy_reg;
  logic busy_next;
  logic [23:0] count_reg;
  logic [23:0] count_next;

  always_comb begin
    stable_next = stable_reg;
    busy_next = busy_reg;
    count_next = count_reg;
    if (!busy_reg) begin
      if (level_in != stable_reg) begin
        // A change is held off for the full interval before it is believed.
        busy_next = 1'b1;
        count_next = 24'h000001;
      end
    end else if (count_reg >= 24'(DEBOUNCE_CYCLES)) begin
      // Whatever level stands now becomes the new state; bounces in between are ignored.
      stable_next = level_in;
      busy_next = 1'b0;
      count_next = 24'h000000;
    end else begin
      count_next = count_reg + 24'h000001;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stable_reg <= MIC_BUTTON_RESET;
      busy_reg <= 1'b0;
      count_reg <= 24'h000000;
    end else begin
      stable_reg <= stable_next;
      busy_reg <= busy_next;
      count_reg <= count_next;
    end
  end

  assign stable_out = stable_reg;

endmodule : mic_debounce

// ### rtl/mic_conditioning.sv
// Mouse input conditioning: button debounce, wheel decode and sensor/lamp power control.
// Assumes pins are asynchronous to ref_clk_in and that suspend_in comes from on-chip logic.
// Operation
// - Button changes ignored until 15 ms pass.
// - Inputs map to left, middle, right buttons.
// - Drive sensor power while operating, release suspended.
// - Sample both wheel phases every 100 us.
// - Mechanical variant: pull-ups on only while operating.
// - Optical variant: wheel inputs never pulled up.
// - A leads counts up, B leads down.
// - Lamp sinks current while operating, off suspended.
`timescale 1ns/1ps
module mic_conditioning
  import mic_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYCLES = MIC_DEBOUNCE_CYCLES,
  parameter int unsigned SAMPLE_CYCLES = MIC_SAMPLE_CYCLES,
  parameter int unsigned SCROLL_WIDTH = MIC_SCROLL_WIDTH,
  parameter bit OPTICAL_VARIANT = 1'b0
) (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic suspend_in,
  input wire logic left_button_in,
  input wire logic middle_button_in,
  input wire logic right_button_in,
  input wire logic wheel_phase_a_in,
  input wire logic wheel_phase_b_in,
  output logic left_pressed_out,
  output logic middle_pressed_out,
  output logic right_pressed_out,
  output logic [SCROLL_WIDTH-1:0] scroll_count_out,
  output logic scroll_step_out,
  output logic sensor_power_ctl_out,
  output logic lamp_drive_out,
  output logic wheel_pullup_en_out
);

  // Five pins pass a three-stage synchroniser: three buttons, then phase A and B.
  localparam int unsigned NPIN = MIC_BUTTONS + 2;

  logic [NPIN-1:0] pins;
  logic [NPIN-1:0] sync1_reg;
  logic [NPIN-1:0] sync2_reg;
  logic [NPIN-1:0] sync3_reg;
  logic [NPIN-1:0] clean_reg;
  logic [NPIN-1:0] clean_next;
  logic [MIC_BUTTONS-1:0] stable;

  assign pins = {wheel_phase_b_in, wheel_phase_a_in,
                 right_button_in, middle_button_in, left_button_in};

  // A pin counts as changed only once the second and third stages agree.
  always_comb begin
    clean_next = clean_reg;
    for (int i = 0; i < NPIN; i++) begin
      if (sync2_reg[i] == sync3_reg[i]) begin
        clean_next[i] = sync3_reg[i];
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync1_reg <= '1;
      sync2_reg <= '1;
      sync3_reg <= '1;
      clean_reg <= '1;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      clean_reg <= clean_next;
    end
  end

  genvar g;
  generate
    for (g = 0; g < MIC_BUTTONS; g++) begin : gen_button
      mic_debounce #(
        .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
      ) u_debounce (
        .ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .level_in(clean_reg[g]),
        .stable_out(stable[g])
      );
    end
  endgenerate

  // Buttons pull to ground when pressed, so pressed is the inverted stable level.
  logic [MIC_BUTTONS-1:0] pressed_reg;
  logic [MIC_BUTTONS-1:0] pressed_next;

  always_comb begin
    pressed_next = ~stable;
  end

  // Sample tick, encoder state machine and scroll count.
  logic [15:0] tick_reg;
  logic [15:0] tick_next;
  logic [1:0] phase_reg;
  logic [1:0] phase_next;
  mic_wheel_state_type wstate_reg;
  mic_wheel_state_type wstate_next;
  logic [SCROLL_WIDTH-1:0] count_reg;
  logic [SCROLL_WIDTH-1:0] count_next;
  localparam logic [SCROLL_WIDTH-1:0] SCROLL_ONE = {{(SCROLL_WIDTH-1){1'b0}}, 1'b1};
  logic step_reg;
  logic step_next;
  logic up_first_reg;
  logic up_first_next;
  logic sample_now;
  logic [1:0] ab;

  assign sample_now = (tick_reg >= 16'(SAMPLE_CYCLES - 1));
  assign ab = phase_reg;

  always_comb begin
    tick_next = sample_now ? 16'h0000 : tick_reg + 16'h0001;
    phase_next = phase_reg;
    wstate_next = wstate_reg;
    count_next = count_reg;
    step_next = 1'b0;
    up_first_next = up_first_reg;
    if (sample_now) begin
      // Phases are taken only on the sample tick, {B, A}.
      phase_next = {clean_reg[4], clean_reg[3]};
    end
    // The decoder acts on the registered sample, one cycle after each tick.
    case (wstate_reg)
      MIC_REST_LOW: begin
        // Detent with both phases low; A alone rising means A leads.
        if (ab == 2'h1) begin
          wstate_next = MIC_MID_UP;
          up_first_next = 1'b1;
        end else if (ab == 2'h2) begin
          wstate_next = MIC_MID_UP;
          up_first_next = 1'b0;
        end else if (ab == 2'h3) begin
          wstate_next = MIC_REST_HIGH;
        end
      end
      MIC_REST_HIGH: begin
        // From the high detent, A falling first also counts up.
        if (ab == 2'h2) begin
          wstate_next = MIC_MID_DOWN;
          up_first_next = 1'b1;
        end else if (ab == 2'h1) begin
          wstate_next = MIC_MID_DOWN;
          up_first_next = 1'b0;
        end else if (ab == 2'h0) begin
          wstate_next = MIC_REST_LOW;
        end
      end
      MIC_MID_UP: begin
        if (ab == 2'h3) begin
          wstate_next = MIC_REST_HIGH;
          count_next = up_first_reg ? count_reg + SCROLL_ONE : count_reg - SCROLL_ONE;
          step_next = 1'b1;
        end else if (ab == 2'h0) begin
          // Wheel went back to where it started: no count.
          wstate_next = MIC_REST_LOW;
        end
      end
      MIC_MID_DOWN: begin
        if (ab == 2'h0) begin
          wstate_next = MIC_REST_LOW;
          count_next = up_first_reg ? count_reg + SCROLL_ONE : count_reg - SCROLL_ONE;
          step_next = 1'b1;
        end else if (ab == 2'h3) begin
          wstate_next = MIC_REST_HIGH;
        end
      end
      default: begin
        wstate_next = MIC_REST_LOW;
      end
    endcase
  end

  // Power outputs: a pulled-up mechanical encoder idles high, so in suspend the
  // pull-ups drop to save current; the optical variant never has them.
  logic power_reg;
  logic power_next;
  logic pullup_reg;
  logic pullup_next;

  always_comb begin
    power_next = !suspend_in;
    pullup_next = OPTICAL_VARIANT ? 1'b0 : !suspend_in;
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pressed_reg <= '0;
      tick_reg <= 16'h0000;
      phase_reg <= MIC_PHASE_RESET;
      wstate_reg <= MIC_REST_LOW;
      count_reg <= '0;
      step_reg <= 1'b0;
      up_first_reg <= 1'b0;
      power_reg <= 1'b0;
      pullup_reg <= 1'b0;
    end else begin
      pressed_reg <= pressed_next;
      tick_reg <= tick_next;
      phase_reg <= phase_next;
      wstate_reg <= wstate_next;
      count_reg <= count_next;
      step_reg <= step_next;
      up_first_reg <= up_first_next;
      power_reg <= power_next;
      pullup_reg <= pullup_next;
    end
  end

  assign left_pressed_out = pressed_reg[0];
  assign middle_pressed_out = pressed_reg[1];
  assign right_pressed_out = pressed_reg[2];
  assign scroll_count_out = count_reg;
  assign scroll_step_out = step_reg;
  assign sensor_power_ctl_out = power_reg;
  assign lamp_drive_out = power_reg;
  assign wheel_pullup_en_out = pullup_reg;

endmodule : mic_conditioning

// ### verif/mic_partner.sv
// Far side model: three bouncing buttons and a contact wheel encoder.
// Assumes the bench moves press_in and wheel_in just after a rising edge.
`timescale 1ns/1ps
module mic_partner (
  input wire logic ref_clk_in,
  input wire logic [2:0] press_in,
  input wire logic [1:0] wheel_in,
  input wire logic pullup_en_in,
  output logic [2:0] button_out,
  output logic [1:0] phase_out
);
  logic [2:0] last_reg = 3'h0;
  int bounce [3] = '{0, 0, 0};
  logic flip = 1'b0;
  // Contacts chatter after every move, so the debouncer never sees a clean edge.
  always @(posedge ref_clk_in) begin
    flip <= !flip;
    last_reg <= press_in;
    for (int i = 0; i < 3; i++) begin
      if (press_in[i] != last_reg[i]) bounce[i] <= 5;
      else if (bounce[i] > 0) bounce[i] <= bounce[i] - 1;
    end
  end
  // An open contact floats without the pull-up, so it reads a changing level.
  always_comb begin
    for (int i = 0; i < 3; i++) button_out[i] = (bounce[i] > 0) ? flip : !press_in[i];
    for (int k = 0; k < 2; k++) phase_out[k] = wheel_in[k] & (pullup_en_in | flip);
  end
endmodule : mic_partner

// ### verif/mic_conditioning_chk.sv
// Port checker for mic_conditioning.
// Assumes one clock domain; bound to every conditioning instance.
`timescale 1ns/1ps
module mic_conditioning_chk #(
  parameter int unsigned DEBOUNCE_CYCLES = 20,
  parameter int unsigned SCROLL_WIDTH = 8,
  parameter bit OPTICAL_VARIANT = 1'b0
) (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic suspend_in,
  input wire logic left_pressed_out,
  input wire logic [SCROLL_WIDTH-1:0] scroll_count_out,
  input wire logic scroll_step_out,
  input wire logic sensor_power_ctl_out,
  input wire logic lamp_drive_out,
  input wire logic wheel_pullup_en_out
);
  logic prev_reg;
  int unsigned age_reg;
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prev_reg <= 1'b0;
      age_reg <= 0;
    end else begin
      prev_reg <= left_pressed_out;
      age_reg <= (left_pressed_out != prev_reg) ? 0 : age_reg + 1;
    end
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  a_power_follow: assert property ($past(reset_n_in) |-> sensor_power_ctl_out == !$past(suspend_in))
    else $error("sensor power does not follow mode");
  a_lamp_follow: assert property ($past(reset_n_in) |-> lamp_drive_out == !$past(suspend_in))
    else $error("lamp does not follow mode");
  a_lamp_resume: assert property ($fell(suspend_in) |=> $rose(lamp_drive_out))
    else $error("lamp not back on resume");
  a_pullup_mode: assert property (wheel_pullup_en_out == (!OPTICAL_VARIANT && sensor_power_ctl_out))
    else $error("wheel pull-up wrong for mode");
  a_count_step: assert property ($changed(scroll_count_out) |-> scroll_step_out)
    else $error("count moved without step");
  a_step_delta: assert property (scroll_step_out |-> scroll_count_out == $past(scroll_count_out) + 1'b1
    || scroll_count_out == $past(scroll_count_out) - 1'b1) else $error("step not one");
  a_step_single: assert property (scroll_step_out |=> !scroll_step_out)
    else $error("step longer than a cycle");
  a_left_debounce: assert property (left_pressed_out != prev_reg |-> age_reg >= DEBOUNCE_CYCLES)
    else $error("button moved inside interval");
  c_step: cover property (scroll_step_out);
  c_press: cover property ($rose(left_pressed_out));
  c_suspend: cover property ($fell(sensor_power_ctl_out));
endmodule : mic_conditioning_chk
bind mic_conditioning mic_conditioning_chk #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES),
  .SCROLL_WIDTH(SCROLL_WIDTH), .OPTICAL_VARIANT(OPTICAL_VARIANT)) u_mic_conditioning_chk (
  .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .suspend_in(suspend_in),
  .left_pressed_out(left_pressed_out), .scroll_count_out(scroll_count_out),
  .scroll_step_out(scroll_step_out), .sensor_power_ctl_out(sensor_power_ctl_out),
  .lamp_drive_out(lamp_drive_out), .wheel_pullup_en_out(wheel_pullup_en_out));

// ### verif/mic_conditioning_tb_top.sv
// Self-checking bench for mic_conditioning with the far side model.
// Assumes short debounce and sample counts so the run stays brief.
`timescale 1ns/1ps
module mic_conditioning_tb_top;
  import mic_pkg::*;
  localparam int unsigned DB = 20;
  localparam int unsigned SC = 8;
  logic ref_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic suspend_in = 1'b0;
  logic [2:0] press = 3'h0;
  logic [1:0] wheel = 2'h0;
  logic [2:0] pin, prs;
  logic [1:0] ph;
  logic [7:0] cnt;
  logic [7:0] exp_cnt = 8'h00;
  logic pwr, lamp, pu;
  logic pu_opt;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  // Each row walks the wheel {A,B} through three positions, starting and ending at a detent.
  logic [1:0] rows_ph [6][3] = '{'{2'h0, 2'h2, 2'h3}, '{2'h3, 2'h1, 2'h0}, '{2'h0, 2'h1, 2'h3},
    '{2'h3, 2'h2, 2'h0}, '{2'h0, 2'h2, 2'h0}, '{2'h0, 2'h3, 2'h3}};
  logic [7:0] rows_d [6] = '{8'h01, 8'h01, 8'hFF, 8'hFF, 8'h00, 8'h00};
  mic_partner u_mic_partner (.ref_clk_in(ref_clk_in), .press_in(press), .wheel_in(wheel),
    .pullup_en_in(pu), .button_out(pin), .phase_out(ph));
  mic_conditioning #(.DEBOUNCE_CYCLES(DB), .SAMPLE_CYCLES(SC)) u_mic_conditioning (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .suspend_in(suspend_in),
    .left_button_in(pin[0]), .middle_button_in(pin[1]), .right_button_in(pin[2]),
    .wheel_phase_a_in(ph[1]), .wheel_phase_b_in(ph[0]), .left_pressed_out(prs[0]),
    .middle_pressed_out(prs[1]), .right_pressed_out(prs[2]), .scroll_count_out(cnt),
    .scroll_step_out(), .sensor_power_ctl_out(pwr), .lamp_drive_out(lamp),
    .wheel_pullup_en_out(pu));
  // The optical variant shares the pins; only its pull-up control is compared here.
  mic_conditioning #(.DEBOUNCE_CYCLES(DB), .SAMPLE_CYCLES(SC), .OPTICAL_VARIANT(1'b1))
    u_mic_conditioning_opt (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .suspend_in(suspend_in),
    .left_button_in(pin[0]), .middle_button_in(pin[1]), .right_button_in(pin[2]),
    .wheel_phase_a_in(ph[1]), .wheel_phase_b_in(ph[0]), .left_pressed_out(),
    .middle_pressed_out(), .right_pressed_out(), .scroll_count_out(),
    .scroll_step_out(), .sensor_power_ctl_out(), .lamp_drive_out(),
    .wheel_pullup_en_out(pu_opt));
  task automatic check_val(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : check_val
  task automatic stop_test;
    if (n_fail == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  always #5 ref_clk_in = !ref_clk_in;
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      stop_test();
    end
  end
  initial begin
    repeat (8) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    check_val("power", 8'h07, {5'h00, pwr, lamp, pu});
    check_val("optical_pullup", 8'h00, {7'h00, pu_opt});
    for (int r = 0; r < 6; r++) begin
      for (int k = 0; k < 3; k++) begin
        wheel <= rows_ph[r][k];
        repeat (2 * SC) @(posedge ref_clk_in);
      end
      exp_cnt = exp_cnt + rows_d[r];
      check_val("scroll_count", exp_cnt, cnt);
    end
    for (int i = 0; i < 3; i++) begin
      press[i] <= 1'b1;
      repeat (DB - 2) @(posedge ref_clk_in);
      check_val("early", 8'h00, {5'h00, prs});
      // Contact chatter lasts five cycles after a move before the clean level holds.
      repeat (20) @(posedge ref_clk_in);
      check_val("pressed", 8'h01 << i, {5'h00, prs});
      press[i] <= 1'b0;
      repeat (DB + 12) @(posedge ref_clk_in);
      press[i] <= 1'b1;
      repeat (3) @(posedge ref_clk_in);
      press[i] <= 1'b0;
      repeat (DB + 12) @(posedge ref_clk_in);
      check_val("glitch", 8'h00, {5'h00, prs});
    end
    suspend_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    check_val("suspended", 8'h00, {5'h00, pwr, lamp, pu});
    suspend_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    check_val("resumed", 8'h07, {5'h00, pwr, lamp, pu});
    check_val("optical_resumed", 8'h00, {7'h00, pu_opt});
    reset_n_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    check_val("in_reset", 8'h00, {5'h00, pwr, lamp, pu});
    reset_n_in <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    check_val("after_reset", 8'h07, {5'h00, pwr, lamp, pu});
    check_val("count_reset", 8'h00, cnt);
    stop_test();
  end
endmodule : mic_conditioning_tb_top
